// file: ltc_pkg.sv
package ltc_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] LTC_OFS_CTRL   = 4'h0;
  localparam logic [3:0] LTC_OFS_PERIOD = 4'h4;
  localparam logic [3:0] LTC_OFS_COUNT  = 4'h8;
  localparam logic [3:0] LTC_OFS_RSTSEL = 4'hC;

  // Control register field positions
  localparam int LTC_CTRL_PRESCALER_OUT_SYNCHRONISE  = 7;
  localparam int LTC_CTRL_INPUT_CLOCK_POLARITY  = 6;
  localparam int LTC_CTRL_CLOCK_ENABLE_RESYNCHRONISE = 5;
  localparam int LTC_CTRL_ON     = 8;
  localparam int LTC_MODE_LSB    = 0;
  localparam int LTC_MODE_W      = 5;

  // External reset source field
  localparam int LTC_RSEL_LSB = 0;
  localparam int LTC_RSEL_W   = 5;
  localparam int LTC_NUM_SRC  = 17;
  localparam logic [4:0] LTC_RSEL_PIN = 5'h00;

  // Widths
  localparam int LTC_CNT_W  = 8;
  localparam int LTC_DATA_W = 32;
  localparam int LTC_ADDR_W = 4;

  // Reset values
  localparam logic [8:0] LTC_CTRL_RST   = 9'h000;
  localparam logic [7:0] LTC_PERIOD_RST = 8'hFF;
  localparam logic [7:0] LTC_COUNT_RST  = 8'h00;
  localparam logic [4:0] LTC_RSEL_RST   = 5'h00;

  // Input clocks skipped after a synchronised start
  localparam logic [1:0] LTC_START_DELAY = 2'h2;
endpackage

// file: ltc_clk_if.sv
interface ltc_clk_if;
  logic input_clock_polarity;
  logic tick;
  modport ctl (output input_clock_polarity, input tick);
  modport edg (input input_clock_polarity, output tick);
endinterface

// file: ltc_edge.sv
module ltc_edge (
  input  wire logic CLOCK,
  input  wire logic RESET_N,
  input  wire logic pin_in,
  ltc_clk_if.edg    cif
);
  import ltc_pkg::*;

  typedef struct packed {
    logic [2:0] sy;
    logic       lvl;
    logic       tick;
  } ltc_edge_s;

  ltc_edge_s st_r;
  ltc_edge_s st_nxt;

  // Three-stage sync, stable level, one tick per selected edge
  always_comb begin
    st_nxt = st_r;
    st_nxt.sy = {st_r.sy[1:0], pin_in};
    st_nxt.tick = 1'b0;
    if (st_r.sy[1] == st_r.sy[2] && st_r.sy[2] != st_r.lvl) begin
      st_nxt.lvl = st_r.sy[2];
      st_nxt.tick = cif.input_clock_polarity ? ~st_r.sy[2] : st_r.sy[2];
    end
  end

  // State register
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cif.tick = st_r.tick;
endmodule // ltc_edge

// file: ltc_top.sv
// Operation
// [R01] With resync set, counting waits two input clocks after run-enable rises.
// [R02] Counting starts when run-enable is one and halts when it is zero.
// [R03] Stopping leaves the counter value untouched.
// [R04] Counter equal to period clears to zero on the next input clock.
// [R05] With prescaler sync set, the timer does not run during sleep.
// [R06] With resync set, run-enable changes only take hold at input clocks.
// [R07] Software changes clock polarity only while the timer is stopped.
// [R08] Reset select bits 7-5 read zero and ignore writes.
// [R09] Bits 4-0 of reset select choose the external reset source.
// [R10] Source code zero routes the selected input pin as external reset.
// [R11] Counter and period are eight bits; wrap happens via period match.
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
module ltc_top (
  input  wire logic                          CLOCK,
  input  wire logic                          RESET_N,
  input  wire logic [ltc_pkg::LTC_ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                          AVS_READ,
  input  wire logic                          AVS_WRITE,
  input  wire logic [ltc_pkg::LTC_DATA_W-1:0] AVS_WRITEDATA,
  input  wire logic [3:0]                    AVS_BYTEENABLE,
  output logic      [ltc_pkg::LTC_DATA_W-1:0] AVS_READDATA,
  output logic                               AVS_WAITREQUEST,
  input  wire logic                          TIMER_CLK_PIN,
  input  wire logic                          SLEEP,
  input  wire logic                          EXT_RESET_PIN,
  input  wire logic [ltc_pkg::LTC_NUM_SRC-1:0] EXT_RESET_SOURCES,
  output logic                               EXT_RESET_OUT,
  output logic      [ltc_pkg::LTC_CNT_W-1:0] COUNT_OUT,
  output logic                               PERIOD_MATCH
);
  import ltc_pkg::*;

  typedef struct packed {
    logic                  ack;
    logic [LTC_DATA_W-1:0] rdata;
    logic                  prescaler_out_synchronise;
    logic                  input_clock_polarity;
    logic                  clock_enable_resynchronise;
    logic                  on;
    logic [LTC_MODE_W-1:0] mode;
    logic [LTC_CNT_W-1:0]  period;
    logic [LTC_CNT_W-1:0]  count;
    logic [LTC_RSEL_W-1:0] rsel;
    logic                  on_sync;
    logic [1:0]            dly;
    logic [2:0]            pin_sy;
    logic                  pin_lvl;
    logic                  ext_out;
    logic                  match;
  } ltc_state_s;

  ltc_state_s st_r;
  ltc_state_s st_nxt;
  ltc_clk_if  cif ();

  logic                  wr_commit;
  logic                  rd_take;
  logic                  cnt_wr;
  logic                  on_eff;
  logic                  run;
  logic                  ext_sel;
  logic [LTC_DATA_W-1:0] rd_val;

  // Input clock edge detector
  ltc_edge u_edge (
    .CLOCK   (CLOCK),
    .RESET_N (RESET_N),
    .pin_in  (TIMER_CLK_PIN),
    .cif     (cif)
  );

  assign cif.input_clock_polarity = st_r.input_clock_polarity;

  // Bus handshake: one wait cycle, commit at the edge with wait low
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~st_r.ack;
  assign wr_commit = AVS_WRITE & st_r.ack & AVS_BYTEENABLE[0];
  assign rd_take = AVS_READ & ~st_r.ack;
  assign cnt_wr = wr_commit && AVS_ADDRESS == LTC_OFS_COUNT;

  // Effective run enable, sampled at input clocks when resync is set
  assign on_eff = st_r.clock_enable_resynchronise ? st_r.on_sync : st_r.on; // [R06]
  assign run = on_eff && !(st_r.prescaler_out_synchronise && SLEEP) && st_r.dly == 2'h0; // [R02] [R05]

  // External reset source mux
  always_comb begin
    ext_sel = 1'b0;
    if (st_r.rsel == LTC_RSEL_PIN) begin
      ext_sel = st_r.pin_lvl; // [R10]
    end else if (st_r.rsel <= LTC_RSEL_W'(LTC_NUM_SRC)) begin
      ext_sel = EXT_RESET_SOURCES[st_r.rsel - 5'h01]; // [R09]
    end
  end

  // Read data selection
  always_comb begin
    rd_val = '0;
    case (AVS_ADDRESS)
      LTC_OFS_CTRL: begin
        rd_val[LTC_CTRL_ON] = st_r.on;
        rd_val[LTC_CTRL_PRESCALER_OUT_SYNCHRONISE] = st_r.prescaler_out_synchronise;
        rd_val[LTC_CTRL_INPUT_CLOCK_POLARITY] = st_r.input_clock_polarity;
        rd_val[LTC_CTRL_CLOCK_ENABLE_RESYNCHRONISE] = st_r.clock_enable_resynchronise;
        rd_val[LTC_MODE_LSB +: LTC_MODE_W] = st_r.mode;
      end
      LTC_OFS_PERIOD: begin
        rd_val[LTC_CNT_W-1:0] = st_r.period;
      end
      LTC_OFS_COUNT: begin
        rd_val[LTC_CNT_W-1:0] = st_r.count;
      end
      LTC_OFS_RSTSEL: begin
        rd_val[LTC_RSEL_LSB +: LTC_RSEL_W] = st_r.rsel; // [R08]
      end
      default: begin
        rd_val = '0;
      end
    endcase
  end

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = (AVS_READ | AVS_WRITE) & ~st_r.ack;
    if (rd_take) begin
      st_nxt.rdata = rd_val;
    end
    // Register writes
    if (wr_commit) begin
      case (AVS_ADDRESS)
        LTC_OFS_CTRL: begin
          st_nxt.on = AVS_WRITEDATA[LTC_CTRL_ON];
          st_nxt.prescaler_out_synchronise = AVS_WRITEDATA[LTC_CTRL_PRESCALER_OUT_SYNCHRONISE];
          st_nxt.input_clock_polarity = AVS_WRITEDATA[LTC_CTRL_INPUT_CLOCK_POLARITY];
          st_nxt.clock_enable_resynchronise = AVS_WRITEDATA[LTC_CTRL_CLOCK_ENABLE_RESYNCHRONISE];
          st_nxt.mode = AVS_WRITEDATA[LTC_MODE_LSB +: LTC_MODE_W];
        end
        LTC_OFS_PERIOD: begin
          st_nxt.period = AVS_WRITEDATA[LTC_CNT_W-1:0];
        end
        LTC_OFS_RSTSEL: begin
          st_nxt.rsel = AVS_WRITEDATA[LTC_RSEL_LSB +: LTC_RSEL_W]; // [R08]
        end
        default: begin
        end
      endcase
    end
    // Run enable resync and start delay, both paced by input clocks
    if (cif.tick) begin
      st_nxt.on_sync = st_r.on; // [R06]
      if (st_r.clock_enable_resynchronise && st_r.on && !st_r.on_sync) begin
        st_nxt.dly = LTC_START_DELAY; // [R01]
      end else if (st_r.dly != 2'h0 && on_eff) begin
        st_nxt.dly = st_r.dly - 2'h1; // [R01]
      end
    end
    // Without resync the sampled enable is parked low, so a later
    // resynchronised start always sees a fresh rise and loads the delay
    if (!st_r.clock_enable_resynchronise) begin
      st_nxt.dly = 2'h0;
      st_nxt.on_sync = 1'b0; // [R01] [R06]
    end
    // Counter: bus write wins, else count or clear at period match
    if (cnt_wr) begin
      st_nxt.count = AVS_WRITEDATA[LTC_CNT_W-1:0];
    end else if (cif.tick && run) begin
      if (st_r.count == st_r.period) begin
        st_nxt.count = '0; // [R04] [R11]
      end else begin
        st_nxt.count = st_r.count + 8'h01;
      end
    end // Halted: count kept as is [R03]
    st_nxt.match = st_nxt.count == st_nxt.period;
    // External reset pin sync and selected source register
    st_nxt.pin_sy = {st_r.pin_sy[1:0], EXT_RESET_PIN};
    if (st_r.pin_sy[1] == st_r.pin_sy[2]) begin
      st_nxt.pin_lvl = st_r.pin_sy[2];
    end
    st_nxt.ext_out = ext_sel;
  end

  // State register
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r <= '0;
      st_r.period <= LTC_PERIOD_RST;
      st_r.count <= LTC_COUNT_RST;
      st_r.rsel <= LTC_RSEL_RST;
      st_r.on <= LTC_CTRL_RST[LTC_CTRL_ON];
    end else begin
      st_r <= st_nxt;
    end
  end

  assign AVS_READDATA = st_r.rdata;
  assign EXT_RESET_OUT = st_r.ext_out;
  assign COUNT_OUT = st_r.count;
  assign PERIOD_MATCH = st_r.match;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  a_start_delay: assert property ( // [R01]
    $rose(st_r.on_sync) && st_r.clock_enable_resynchronise |-> st_r.dly == 2'h2)
    else $error("start delay not loaded");
  a_run_counts: assert property ( // [R02]
    cif.tick && run && !cnt_wr && st_r.count != st_r.period
    |=> st_r.count == $past(st_r.count) + 8'h01)
    else $error("running timer failed to count");
  a_stop_holds: assert property ( // [R03]
    !on_eff && !cnt_wr |=> $stable(st_r.count))
    else $error("stopped counter changed");
  a_period_clear: assert property ( // [R04]
    cif.tick && run && !cnt_wr && st_r.count == st_r.period
    |=> st_r.count == 8'h00)
    else $error("period match did not clear");
  a_sleep_halt: assert property ( // [R05]
    st_r.prescaler_out_synchronise && SLEEP && !cnt_wr |=> $stable(st_r.count))
    else $error("timer ran in sleep");
  a_glitch_free: assert property ( // [R06]
    st_r.clock_enable_resynchronise && $changed(st_r.on_sync) |-> $past(cif.tick))
    else $error("enable changed off input clock");
  a_rsel_upper: assert property ( // [R08]
    AVS_ADDRESS == LTC_OFS_RSTSEL && rd_take |=> AVS_READDATA[7:5] == 3'h0)
    else $error("reserved reset select bits nonzero");
  a_rsel_route: assert property ( // [R10]
    st_r.rsel == 5'h00 |=> EXT_RESET_OUT == $past(st_r.pin_lvl))
    else $error("pin not routed as external reset");
  a_wait_bound: assert property (
    AVS_READ || AVS_WRITE |-> ##[0:1] !AVS_WAITREQUEST)
    else $error("waitrequest held too long");

  c_match_clear: cover property (cif.tick && run && st_r.match);
  c_sync_start: cover property ($rose(st_r.on_sync) && st_r.clock_enable_resynchronise);
  c_sleep_hold: cover property (st_r.prescaler_out_synchronise && SLEEP && on_eff);
  c_src_select: cover property (st_r.rsel == 5'h05 && EXT_RESET_OUT);
endmodule // ltc_top

// file: tb_limit_timer_control.sv
module tb_limit_timer_control;
  timeunit 1ns;
  timeprecision 100ps;
  import ltc_pkg::*;
  logic        CLOCK, RESET_N, AVS_READ, AVS_WRITE, TIMER_CLK_PIN;
  logic        SLEEP, EXT_RESET_PIN, EXT_RESET_OUT, PERIOD_MATCH;
  logic        AVS_WAITREQUEST;
  logic [3:0]  AVS_ADDRESS, AVS_BYTEENABLE;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  logic [16:0] EXT_RESET_SOURCES;
  logic [7:0]  COUNT_OUT, per;
  logic [31:0] exp_q[$];
  int          n_fail, compares, seed, k;

  ltc_top u_ltc_top (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .TIMER_CLK_PIN(TIMER_CLK_PIN), .SLEEP(SLEEP),
    .EXT_RESET_PIN(EXT_RESET_PIN), .EXT_RESET_SOURCES(EXT_RESET_SOURCES),
    .EXT_RESET_OUT(EXT_RESET_OUT), .COUNT_OUT(COUNT_OUT),
    .PERIOD_MATCH(PERIOD_MATCH));

  // 40 MHz clock
  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end

  task automatic close_out();
    $display("Checks %0d failures %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One Avalon cycle; a read leaves its expected word in the queue
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    if (!w)
      exp_q.push_back(d);
    @(posedge CLOCK);
    AVS_ADDRESS   <= a;
    AVS_WRITE     <= w;
    AVS_READ      <= !w;
    AVS_WRITEDATA <= w ? d : 32'h0000_0000;
    for (n = 0; n < 20; n++) begin
      @(posedge CLOCK);
      if (!AVS_WAITREQUEST)
        break;
    end
    if (n < 20) begin
      AVS_READ  <= 1'b0;
      AVS_WRITE <= 1'b0;
    end else begin
      n_fail++;
      close_out();
    end
  endtask

  // Timer pin pulses, each edge held well past the synchroniser
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge CLOCK);
      TIMER_CLK_PIN <= 1'b1;
      repeat (5) @(posedge CLOCK);
      TIMER_CLK_PIN <= 1'b0;
      repeat (5) @(posedge CLOCK);
    end
    repeat (5) @(posedge CLOCK);
  endtask

  // Read data compared against the oldest note at the accepting edge
  always @(posedge CLOCK) begin
    if (AVS_READ && !AVS_WAITREQUEST)
      check("readdata", AVS_READDATA, exp_q.pop_front());
  end

  // Main sequence
  initial begin
    seed = 32'h3a179353;
    {RESET_N, AVS_READ, AVS_WRITE, TIMER_CLK_PIN, SLEEP} = '0;
    {AVS_ADDRESS, AVS_WRITEDATA, EXT_RESET_PIN} = '0;
    AVS_BYTEENABLE = 4'hF;
    EXT_RESET_SOURCES = 17'($random(seed));
    per = 8'h03 + 8'($random(seed) & 3);
    repeat (4) @(posedge CLOCK);
    RESET_N <= 1'b1;
    bus(0, LTC_OFS_CTRL, 32'h0000_0000);
    bus(0, LTC_OFS_PERIOD, 32'h0000_00FF);
    bus(0, LTC_OFS_COUNT, 32'h0000_0000);
    bus(0, LTC_OFS_RSTSEL, 32'h0000_0000);
    bus(1, LTC_OFS_RSTSEL, 32'h0000_00FF);
    bus(0, LTC_OFS_RSTSEL, 32'h0000_001F);
    bus(1, 4'h1, 32'h0000_0055);
    bus(0, 4'h1, 32'h0000_0000);
    AVS_BYTEENABLE <= 4'h0;
    bus(1, LTC_OFS_PERIOD, 32'h0000_0012);
    AVS_BYTEENABLE <= 4'hF;
    bus(0, LTC_OFS_PERIOD, 32'h0000_00FF);
    // Plain counting, wrapping through the period match only when per is 3 or 4, then stop
    bus(1, LTC_OFS_PERIOD, {24'h0, per});
    bus(1, LTC_OFS_CTRL, 32'h0000_0100);
    tick(5);
    bus(0, LTC_OFS_COUNT, 32'(5 % (per + 1)));
    bus(1, LTC_OFS_CTRL, 32'h0000_0000);
    tick(3);
    bus(0, LTC_OFS_COUNT, 32'(5 % (per + 1)));
    @(negedge CLOCK);
    check("count_out", 32'(COUNT_OUT), 32'(5 % (per + 1)));
    check("period_match", 32'(PERIOD_MATCH),
          32'((5 % (per + 1)) == per));
    // Falling-edge polarity chosen while stopped
    bus(1, LTC_OFS_CTRL, 32'h0000_0040);
    bus(1, LTC_OFS_COUNT, 32'h0000_0000);
    bus(1, LTC_OFS_CTRL, 32'h0000_0140);
    tick(2);
    bus(0, LTC_OFS_COUNT, 32'h0000_0002);
    bus(1, LTC_OFS_CTRL, 32'h0000_0000);
    // Resynchronised start skips the first input clocks
    bus(1, LTC_OFS_COUNT, 32'h0000_0000);
    bus(1, LTC_OFS_CTRL, 32'h0000_0120);
    tick(5);
    bus(0, LTC_OFS_COUNT, 32'h0000_0002);
    bus(1, LTC_OFS_CTRL, 32'h0000_0000);
    // Sleep with prescaler sync holds the count
    bus(1, LTC_OFS_COUNT, 32'h0000_0000);
    SLEEP <= 1'b1;
    bus(1, LTC_OFS_CTRL, 32'h0000_0180);
    tick(3);
    bus(0, LTC_OFS_COUNT, 32'h0000_0000);
    SLEEP <= 1'b0;
    tick(2);
    bus(0, LTC_OFS_COUNT, 32'h0000_0002);
    // External reset source routing, pin first
    bus(1, LTC_OFS_RSTSEL, 32'h0000_0000);
    EXT_RESET_PIN <= 1'b1;
    repeat (8) @(negedge CLOCK);
    check("ext_reset_out", 32'(EXT_RESET_OUT), 32'h1);
    EXT_RESET_PIN <= 1'b0;
    repeat (8) @(negedge CLOCK);
    check("ext_reset_out", 32'(EXT_RESET_OUT), 32'h0);
    for (k = 1; k < 19; k++) begin
      bus(1, LTC_OFS_RSTSEL, 32'(k));
      repeat (3) @(negedge CLOCK);
      check("ext_reset_out", 32'(EXT_RESET_OUT),
            32'(k < 18 ? EXT_RESET_SOURCES[k-1] : 1'b0));
    end
    repeat (4) @(posedge CLOCK);
    close_out();
  end
endmodule // tb_limit_timer_control
